/* File: hw/dsp_ctrl_pkg.sv */
// Package: offsets, reset values and carriers for the control register bank
package dsp_ctrl_pkg;
  localparam int ADDR_W = 12;
  localparam int NUM_SAVED = 8;
  localparam int NUM_AUX = 4;
  localparam int NUM_PINS = 12;
  localparam int PARAM_W = 28;
  localparam int AUX_W = 12;
  localparam int MODE_W = 4;
  localparam int PINS_PER_CFG = 6;
  // Register offsets
  localparam logic [11:0] SAVED_PARAM_0_OFS = 12'h800;
  localparam logic [11:0] SAVED_PARAM_7_OFS = 12'h807;
  localparam logic [11:0] PIN_LEVEL_SETTING_OFS = 12'h808;
  localparam logic [11:0] AUX_CONV_RESULT_0_OFS = 12'h809;
  localparam logic [11:0] AUX_CONV_RESULT_3_OFS = 12'h80c;
  localparam logic [11:0] PIN_CONFIG_LOW_OFS = 12'h820;
  localparam logic [11:0] PIN_CONFIG_HIGH_OFS = 12'h821;
  localparam logic [11:0] AUX_CONV_POWER_CONTROL_OFS = 12'h822;
  localparam logic [11:0] RESERVED_A_OFS = 12'h823;
  localparam logic [11:0] AUX_CONV_ENABLE_OFS = 12'h824;
  localparam logic [11:0] RESERVED_B_OFS = 12'h825;
  localparam logic [11:0] OSCILLATOR_POWER_DOWN_OFS = 12'h826;
  localparam logic [11:0] OUTPUT_CONVERTER_SETUP_OFS = 12'h827;
  // Field positions
  localparam int SMOOTH_LSB = 8;
  localparam int AUX_PD_BIT = 7;
  localparam int BIAS_PD_BIT = 6;
  localparam int VREF_PD_BIT = 5;
  localparam int AUX_EN_BIT = 15;
  localparam int OSC_PD_BIT = 2;
  localparam int AUX_PARAM_LSB = 12;
  localparam int AUX_COARSE_BITS = 4;
  // Reset values
  localparam logic [27:0] SAVED_PARAM_RST = 28'h0000000;
  localparam logic [11:0] PIN_LEVEL_RST = 12'h000;
  localparam logic [23:0] PIN_CONFIG_RST = 24'h000000;
  localparam logic [15:0] CTRL16_RST = 16'h0000;
  localparam logic [11:0] AUX_RESULT_RST = 12'h000;

  // Power and converter control fields
  typedef struct packed {
    logic [1:0] aux_smoothing_select;
    logic aux_conv_power_down;
    logic bias_ref_power_down;
    logic voltage_ref_power_down;
    logic out_conv0_power_down;
    logic out_conv1_power_down;
    logic out_conv2_power_down;
    logic out_conv3_power_down;
    logic aux_conv_enable_bit;
    logic osc_power_down_bit;
    logic [1:0] out_conv_setup_field;
  } power_ctrl_s;

  // Host register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } reg_req_s;
endpackage

/* File: hw/dsp_ctrl_regs.sv */
// Control register bank: saved parameters, pin setup, auxiliary converter, power
//
// How it works
// - Eight 32-bit save registers, 28-bit parameter low, top four bits read zero.
// - Core refreshes save registers each sample period unless host write mode.
// - Chosen edge on save trigger requests EEPROM save; polarity selectable.
// - After reset, parameters reloaded from EEPROM restore the save registers.
// - Host writes save registers only in host write mode; core stops updating.
// - Save register parameter sits in bits 27:0, resets to zero.
// - Pin level register at 0x808 holds twelve pin levels, bits 15:12 zero.
// - Four auxiliary converter results at 0x809 to 0x80c, one per channel.
// - Results are eight bits, twelve bits when smoothing select is nonzero.
// - Core sees each result as unsigned 1.11 word.
// - Two 24-bit pin config registers, six 4-bit modes each, reset zero.
// - Register 0x822 holds smoothing select and power-down bits, resets zero.
// - Undefined bit positions hold no state and read zero.
// - Host may write converter results when aux host write bit set.
// - Result code 0x800 maps to 1.0 in 5.23 word, top 4, low 12 zero.
`timescale 1ns/1ps
`default_nettype none
module dsp_ctrl_regs (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Control port register access
  input wire dsp_ctrl_pkg::reg_req_s reg_req_in,
  output logic [31:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Core control mode bits
  input wire logic host_write_saved_regs_in,
  input wire logic host_write_aux_results_in,
  // Core side
  input wire logic sample_tick_in,
  input wire logic [dsp_ctrl_pkg::NUM_SAVED*dsp_ctrl_pkg::PARAM_W-1:0] core_params_in,
  input wire logic aux_sample_valid_in,
  input wire logic [1:0] aux_sample_chan_in,
  input wire logic [dsp_ctrl_pkg::AUX_W-1:0] aux_sample_in,
  output logic [dsp_ctrl_pkg::NUM_AUX*dsp_ctrl_pkg::AUX_W-1:0] aux_fixed_out,
  output logic [dsp_ctrl_pkg::NUM_AUX*dsp_ctrl_pkg::PARAM_W-1:0] aux_param_out,
  // EEPROM save and restore
  input wire logic save_trigger_in,
  input wire logic save_on_rising_in,
  output logic eeprom_save_req_out,
  output logic [dsp_ctrl_pkg::NUM_SAVED*dsp_ctrl_pkg::PARAM_W-1:0] saved_params_out,
  input wire logic restore_valid_in,
  input wire logic [2:0] restore_index_in,
  input wire logic [dsp_ctrl_pkg::PARAM_W-1:0] restore_data_in,
  // Pins and analog control
  output logic [dsp_ctrl_pkg::NUM_PINS-1:0] pin_level_bits_out,
  output logic [dsp_ctrl_pkg::NUM_PINS*dsp_ctrl_pkg::MODE_W-1:0] pin_mode_out,
  output dsp_ctrl_pkg::power_ctrl_s power_ctrl_out
);
  localparam int PW = dsp_ctrl_pkg::PARAM_W;
  localparam int AW = dsp_ctrl_pkg::AUX_W;

  logic [PW-1:0] saved_reg [dsp_ctrl_pkg::NUM_SAVED];
  logic [AW-1:0] aux_reg [dsp_ctrl_pkg::NUM_AUX];
  logic [11:0] pin_level_reg;
  logic [23:0] pin_cfg_lo_reg;
  logic [23:0] pin_cfg_hi_reg;
  logic [9:0] pwr_reg;
  logic aux_en_reg;
  logic osc_pd_reg;
  logic [1:0] setup_reg;
  logic trig_s1_reg;
  logic trig_s2_reg;
  logic trig_s3_reg;
  logic [2:0] trig_ok_reg;
  logic save_req_reg;
  logic [31:0] rdata_reg;
  logic rvalid_reg;
  logic [31:0] rdata_next;
  logic wr;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic saved_hit;
  logic aux_hit;
  logic [2:0] saved_idx;
  logic [1:0] aux_idx;

  assign wr = reg_req_in.wr;
  assign addr = reg_req_in.addr;
  assign wdata = reg_req_in.wdata;
  assign saved_hit = (addr >= dsp_ctrl_pkg::SAVED_PARAM_0_OFS) &&
                     (addr <= dsp_ctrl_pkg::SAVED_PARAM_7_OFS);
  assign aux_hit = (addr >= dsp_ctrl_pkg::AUX_CONV_RESULT_0_OFS) &&
                   (addr <= dsp_ctrl_pkg::AUX_CONV_RESULT_3_OFS);
  assign saved_idx = 3'(addr - dsp_ctrl_pkg::SAVED_PARAM_0_OFS);
  assign aux_idx = 2'(addr - dsp_ctrl_pkg::AUX_CONV_RESULT_0_OFS);

  // ---------------------------------------------------------------
  // Saved parameter registers
  // ---------------------------------------------------------------
  // Restore beats the host and core so a boot reload is never lost to a host write or core refresh in the same cycle
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < dsp_ctrl_pkg::NUM_SAVED; i++) begin
        saved_reg[i] <= dsp_ctrl_pkg::SAVED_PARAM_RST;
      end
    end else if (restore_valid_in) begin
      saved_reg[restore_index_in] <= restore_data_in;
    end else if (host_write_saved_regs_in) begin
      if (wr && saved_hit) begin
        saved_reg[saved_idx] <= wdata[PW-1:0];
      end
    end else if (sample_tick_in) begin
      for (int i = 0; i < dsp_ctrl_pkg::NUM_SAVED; i++) begin
        saved_reg[i] <= core_params_in[i*PW +: PW];
      end
    end
  end

  // ---------------------------------------------------------------
  // Save trigger
  // ---------------------------------------------------------------
  // Detector held off until both stages carry real pin samples:
  // reset stage values would fake an edge when the pin idles high
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      trig_s1_reg <= 1'b0;
      trig_s2_reg <= 1'b0;
      trig_s3_reg <= 1'b0;
      trig_ok_reg <= 3'h0;
      save_req_reg <= 1'b0;
    end else begin
      trig_s1_reg <= save_trigger_in;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
      trig_ok_reg <= {trig_ok_reg[1:0], 1'b1};
      save_req_reg <= trig_ok_reg[2] &&
                      (save_on_rising_in ? (trig_s2_reg && !trig_s3_reg)
                                         : (!trig_s2_reg && trig_s3_reg));
    end
  end

  // ---------------------------------------------------------------
  // Auxiliary converter results
  // ---------------------------------------------------------------
  // Coarse mode drops the low bits so unsmoothed jitter never leaks
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < dsp_ctrl_pkg::NUM_AUX; i++) begin
        aux_reg[i] <= dsp_ctrl_pkg::AUX_RESULT_RST;
      end
    end else if (host_write_aux_results_in) begin
      if (wr && aux_hit) begin
        aux_reg[aux_idx] <= wdata[AW-1:0];
      end
    end else if (aux_sample_valid_in) begin
      if (pwr_reg[9:8] != 2'h0) begin
        aux_reg[aux_sample_chan_in] <= aux_sample_in;
      end else begin
        aux_reg[aux_sample_chan_in] <= {aux_sample_in[AW-1:dsp_ctrl_pkg::AUX_COARSE_BITS],
                                        4'h0};
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin and power control registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pin_level_reg <= dsp_ctrl_pkg::PIN_LEVEL_RST;
      pin_cfg_lo_reg <= dsp_ctrl_pkg::PIN_CONFIG_RST;
      pin_cfg_hi_reg <= dsp_ctrl_pkg::PIN_CONFIG_RST;
      pwr_reg <= dsp_ctrl_pkg::CTRL16_RST[9:0];
      aux_en_reg <= 1'b0;
      osc_pd_reg <= 1'b0;
      setup_reg <= 2'h0;
    end else if (wr) begin
      unique case (addr)
        dsp_ctrl_pkg::PIN_LEVEL_SETTING_OFS: pin_level_reg <= wdata[11:0];
        dsp_ctrl_pkg::PIN_CONFIG_LOW_OFS: pin_cfg_lo_reg <= wdata[23:0];
        dsp_ctrl_pkg::PIN_CONFIG_HIGH_OFS: pin_cfg_hi_reg <= wdata[23:0];
        dsp_ctrl_pkg::AUX_CONV_POWER_CONTROL_OFS: pwr_reg <= {wdata[9:5], 1'b0, wdata[3:0]};
        dsp_ctrl_pkg::AUX_CONV_ENABLE_OFS: aux_en_reg <= wdata[dsp_ctrl_pkg::AUX_EN_BIT];
        dsp_ctrl_pkg::OSCILLATOR_POWER_DOWN_OFS: osc_pd_reg <= wdata[dsp_ctrl_pkg::OSC_PD_BIT];
        dsp_ctrl_pkg::OUTPUT_CONVERTER_SETUP_OFS: setup_reg <= wdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    rdata_next = 32'h0;
    if (saved_hit) begin
      rdata_next = {4'h0, saved_reg[saved_idx]};
    end else if (aux_hit) begin
      rdata_next = {20'h0, aux_reg[aux_idx]};
    end else begin
      unique case (addr)
        dsp_ctrl_pkg::PIN_LEVEL_SETTING_OFS: rdata_next = {20'h0, pin_level_reg};
        dsp_ctrl_pkg::PIN_CONFIG_LOW_OFS: rdata_next = {8'h0, pin_cfg_lo_reg};
        dsp_ctrl_pkg::PIN_CONFIG_HIGH_OFS: rdata_next = {8'h0, pin_cfg_hi_reg};
        dsp_ctrl_pkg::AUX_CONV_POWER_CONTROL_OFS: rdata_next = {22'h0, pwr_reg[9:5], 1'b0,
                                                                pwr_reg[3:0]};
        dsp_ctrl_pkg::AUX_CONV_ENABLE_OFS: rdata_next = {16'h0, aux_en_reg, 15'h0};
        dsp_ctrl_pkg::OSCILLATOR_POWER_DOWN_OFS: rdata_next = {29'h0, osc_pd_reg, 2'h0};
        dsp_ctrl_pkg::OUTPUT_CONVERTER_SETUP_OFS: rdata_next = {30'h0, setup_reg};
        default: rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rdata_reg <= 32'h0;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_req_in.rd;
      if (reg_req_in.rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Bit 4 of the power register is a hole; it is never stored meaningfully
  always_comb begin
    for (int i = 0; i < dsp_ctrl_pkg::NUM_SAVED; i++) begin
      saved_params_out[i*PW +: PW] = saved_reg[i];
    end
    for (int i = 0; i < dsp_ctrl_pkg::NUM_AUX; i++) begin
      aux_fixed_out[i*AW +: AW] = aux_reg[i];
      aux_param_out[i*PW +: PW] = {4'h0, aux_reg[i], 12'h000};
    end
  end

  assign pin_mode_out = {pin_cfg_hi_reg, pin_cfg_lo_reg};
  assign pin_level_bits_out = pin_level_reg;
  assign eeprom_save_req_out = save_req_reg;
  assign reg_rdata_out = rdata_reg;
  assign reg_rvalid_out = rvalid_reg;
  assign power_ctrl_out = '{
    aux_smoothing_select: pwr_reg[9:8],
    aux_conv_power_down: pwr_reg[dsp_ctrl_pkg::AUX_PD_BIT],
    bias_ref_power_down: pwr_reg[dsp_ctrl_pkg::BIAS_PD_BIT],
    voltage_ref_power_down: pwr_reg[dsp_ctrl_pkg::VREF_PD_BIT],
    out_conv0_power_down: pwr_reg[3],
    out_conv1_power_down: pwr_reg[2],
    out_conv2_power_down: pwr_reg[1],
    out_conv3_power_down: pwr_reg[0],
    aux_conv_enable_bit: aux_en_reg,
    osc_power_down_bit: osc_pd_reg,
    out_conv_setup_field: setup_reg
  };

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  // Pin edges are judged on the synchronised copy, never on the raw pin
  sequence s_rise_seen;
    !trig_s2_reg ##1 trig_s2_reg;
  endsequence

  sequence s_fall_seen;
    trig_s2_reg ##1 !trig_s2_reg;
  endsequence

  a_saved_top_zero: assert property (reg_rvalid_out && $past(saved_hit) |->
    reg_rdata_out[31:28] == 4'h0) else $error("Save register top bits not zero");
  a_core_refresh: assert property (sample_tick_in && !host_write_saved_regs_in &&
    !restore_valid_in |=> saved_params_out == $past(core_params_in))
    else $error("Core refresh missed");
  a_save_rise: assert property (s_rise_seen ##0 (save_on_rising_in && trig_ok_reg[2])
    |=> eeprom_save_req_out) else $error("Rising save request missing");
  a_save_fall: assert property (s_fall_seen ##0 (!save_on_rising_in && trig_ok_reg[2])
    |=> eeprom_save_req_out) else $error("Falling save request missing");
  a_save_quiet: assert property (!trig_ok_reg[2] |=> !eeprom_save_req_out)
    else $error("Save request before trigger settled");
  a_restore_load: assert property (restore_valid_in |=>
    saved_reg[$past(restore_index_in)] == $past(restore_data_in))
    else $error("Restore not loaded");
  a_host_hold: assert property (host_write_saved_regs_in && !restore_valid_in &&
    !(wr && saved_hit) |=> $stable(saved_params_out))
    else $error("Save registers changed in host mode");
  a_pin_level: assert property (wr && addr == dsp_ctrl_pkg::PIN_LEVEL_SETTING_OFS |=>
    pin_level_bits_out == $past(wdata[11:0])) else $error("Pin level not written");
  a_cfg_low: assert property (wr && addr == dsp_ctrl_pkg::PIN_CONFIG_LOW_OFS |=>
    pin_mode_out[23:0] == $past(wdata[23:0])) else $error("Low pin modes not written");
  a_cfg_high: assert property (wr && addr == dsp_ctrl_pkg::PIN_CONFIG_HIGH_OFS |=>
    pin_mode_out[47:24] == $past(wdata[23:0])) else $error("High pin modes not written");
  a_coarse_aux: assert property (aux_sample_valid_in && !host_write_aux_results_in &&
    pwr_reg[9:8] == 2'h0 |=> aux_reg[$past(aux_sample_chan_in)][3:0] == 4'h0)
    else $error("Coarse result has low bits");
  a_aux_host: assert property (host_write_aux_results_in && wr && aux_hit |=>
    aux_reg[$past(aux_idx)] == $past(wdata[AW-1:0])) else $error("Aux host write lost");
  a_reserved_zero: assert property (reg_req_in.rd &&
    (addr == dsp_ctrl_pkg::RESERVED_A_OFS || addr == dsp_ctrl_pkg::RESERVED_B_OFS)
    |=> reg_rdata_out == 32'h0) else $error("Reserved register not zero");
endmodule
`default_nettype wire

/* File: tb/host_port_model.sv */
// Host model on the control port: one-cycle register writes and reads
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  // Clock
  input wire logic mclk_in,
  // Register access
  output var dsp_ctrl_pkg::reg_req_s reg_req_out,
  input wire logic [31:0] reg_rdata_in,
  input wire logic reg_rvalid_in
);
  initial reg_req_out = '0;

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge mclk_in);
    reg_req_out = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge mclk_in);
    reg_req_out.wr = 1'b0;
    // Released data flips so a stale word cannot pass for a held one
    reg_req_out.wdata = ~d;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    int n;
    @(negedge mclk_in);
    reg_req_out = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(negedge mclk_in);
    reg_req_out.rd = 1'b0;
    n = 0;
    while (reg_rvalid_in !== 1'b1 && n < 4) begin
      @(negedge mclk_in);
      n++;
    end
    q = (reg_rvalid_in === 1'b1) ? reg_rdata_in : 32'hdead_beef;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk_in, sys_rst_in, rvalid, hw_saved, hw_aux, tick, aval, trig, pol, rvld, sreq;
  dsp_ctrl_pkg::reg_req_s req;
  dsp_ctrl_pkg::power_ctrl_s pwr;
  logic [31:0] rdata, q, d;
  logic [1:0] achan;
  logic [11:0] araw, levels;
  logic [223:0] core, saved;
  logic [47:0] afix, pmode;
  logic [111:0] apar;
  logic [2:0] ridx;
  logic [27:0] rdat;
  logic [27:0] es [8] = '{default: '0};
  logic [11:0] ea [4] = '{default: '0};
  logic [11:0] ra [9] = '{12'h808, 12'h820, 12'h821, 12'h822, 12'h823, 12'h824, 12'h825,
    12'h826, 12'h827};
  logic [31:0] rm [9] = '{32'hfff, 32'hffffff, 32'hffffff, 32'h3ef, 32'h0, 32'h8000, 32'h0,
    32'h4, 32'h3};
  logic [31:0] wv [9];
  int error_cnt, checked, seed, n, c;

  dsp_ctrl_regs dsp_ctrl_regs_i (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .host_write_saved_regs_in(hw_saved),
    .host_write_aux_results_in(hw_aux), .sample_tick_in(tick), .core_params_in(core),
    .aux_sample_valid_in(aval), .aux_sample_chan_in(achan), .aux_sample_in(araw),
    .aux_fixed_out(afix), .aux_param_out(apar), .save_trigger_in(trig),
    .save_on_rising_in(pol), .eeprom_save_req_out(sreq), .saved_params_out(saved),
    .restore_valid_in(rvld), .restore_index_in(ridx), .restore_data_in(rdat),
    .pin_level_bits_out(levels), .pin_mode_out(pmode), .power_ctrl_out(pwr));
  host_port_model host_port_model_i (.mclk_in(mclk_in), .reg_req_out(req),
    .reg_rdata_in(rdata), .reg_rvalid_in(rvalid));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  function automatic logic [11:0] aux_exp(input logic [1:0] sel, input logic [11:0] raw);
    return (sel != 2'b00) ? raw : {raw[11:4], 4'h0};
  endfunction

  // One sample period; the core refresh is lost while the host owns the registers
  task automatic tick_once;
    @(negedge mclk_in);
    for (int k = 0; k < 8; k++) core[28*k+:28] = 28'($random(seed));
    tick = 1'b1;
    @(negedge mclk_in);
    tick = 1'b0;
    if (!hw_saved) for (int k = 0; k < 8; k++) es[k] = core[28*k+:28];
  endtask

  task automatic edge_cnt(input logic v, output int cnt);
    @(negedge mclk_in);
    trig = v;
    cnt = 0;
    repeat (8) begin
      @(negedge mclk_in);
      cnt += (sreq === 1'b1);
    end
  endtask

  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end

  initial begin
    repeat (5000) @(posedge mclk_in);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    seed = 32'h2e0f;
    {hw_saved, hw_aux, tick, aval, trig, pol, rvld, achan, araw, ridx, rdat} = '0;
    core = '0;
    sys_rst_in = 1'b1;
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in) sys_rst_in = 1'b0;
    // --------------------------------------------
    // Reset values, unmapped holes and plain fields
    // --------------------------------------------
    for (int a = 'h800; a <= 'h830; a++) begin
      host_port_model_i.rd(12'(a), q);
      check(q, 32'h0);
    end
    check({19'h0, pwr}, 32'h0);
    $display("reset test done");
    repeat (2) for (int i = 0; i < 9; i++) begin
      d = (i == 3) ? 32'hffffffff : $random(seed);
      wv[i] = d & rm[i];
      host_port_model_i.wr(ra[i], d);
      host_port_model_i.rd(ra[i], q);
      check(q, wv[i]);
    end
    check({20'h0, levels}, wv[0]);
    check({8'h0, pmode[23:0]}, wv[1]);
    check({8'h0, pmode[47:24]}, wv[2]);
    d = {19'h0, wv[3][9:5], wv[3][3:0], wv[5][15], wv[7][2], wv[8][1:0]};
    check({19'h0, pwr}, d);
    $display("register table test done");
    // --------------------------------------------
    // Saved parameters, converter results, save trigger
    // --------------------------------------------
    for (int i = 0; i < 8; i++) begin
      host_port_model_i.wr(12'h800 + 12'(i), $random(seed));
      host_port_model_i.rd(12'h800 + 12'(i), q);
      check(q, {4'h0, es[i]});
      tick_once();
      host_port_model_i.rd(12'h800 + 12'(i), q);
      check(q, {4'h0, es[i]});
      hw_saved = 1'b1;
      d = $random(seed);
      host_port_model_i.wr(12'h800 + 12'(i), d);
      es[i] = d[27:0];
      tick_once();
      host_port_model_i.rd(12'h800 + 12'(i), q);
      check(q, {4'h0, es[i]});
      @(negedge mclk_in);
      ridx = 3'(i);
      rdat = 28'($random(seed));
      rvld = 1'b1;
      @(negedge mclk_in);
      rvld = 1'b0;
      es[i] = rdat;
      check({4'h0, saved[28*i+:28]}, {4'h0, es[i]});
      hw_saved = 1'b0;
    end
    $display("saved parameter test done");
    for (int j = 0; j < 12; j++) begin
      hw_aux = (j >= 8);
      // Reserved bits of the control word kept at zero
      host_port_model_i.wr(12'h822, {22'h0, 2'(j), 8'h0});
      @(negedge mclk_in);
      c = $random(seed) & 3;
      achan = 2'(c);
      araw = (j == 0) ? 12'hfff : 12'($random(seed));
      aval = 1'b1;
      @(negedge mclk_in);
      aval = 1'b0;
      d = $random(seed);
      host_port_model_i.wr(12'h809 + 12'(c), d);
      ea[c] = hw_aux ? d[11:0] : aux_exp(2'(j), araw);
      host_port_model_i.rd(12'h809 + 12'(c), q);
      check(q, {20'h0, ea[c]});
      check({20'h0, afix[12*c+:12]}, {20'h0, ea[c]});
      check({4'h0, apar[28*c+:28]}, {8'h0, ea[c], 12'h0});
    end
    $display("converter result test done");
    for (int p = 0; p < 2; p++) begin
      pol = p[0];
      edge_cnt(~pol, n);
      edge_cnt(pol, n);
      check(32'(n), 32'h1);
      edge_cnt(~pol, n);
      check(32'(n), 32'h0);
    end
    $display("save trigger test done");
    // Mid-run reset with the trigger pin high: no false edge, registers cleared
    @(negedge mclk_in);
    trig = 1'b1;
    sys_rst_in = 1'b1;
    repeat (3) @(negedge mclk_in);
    sys_rst_in = 1'b0;
    edge_cnt(1'b1, n);
    check(32'(n), 32'h0);
    check({19'h0, pwr}, 32'h0);
    check({20'h0, levels}, 32'h0);
    host_port_model_i.rd(12'h800, q);
    check(q, 32'h0);
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
